// ===== hw/rtcidx_top.sv
`timescale 1ns/1ps
// Index/data port front end for the internal RTC
module rtcidx_top
    import rtcidx_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] cfg_idx,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    output logic isa_wr,
    output logic [7:0] isa_addr,
    output logic [7:0] isa_data,
    output logic index_latch_strobe,
    output logic [6:0] latch_index,
    output logic nmi_mask,
    output logic [7:0] cfg_shadow_rdata
);
    rtcidx_mem_if mem ();
    rtcidx_mem u_mem (
        .clock(clock),
        .mem(mem)
    );

    logic pri_idx_wr, ext_idx_wr, pri_dat, ext_dat;
    logic [7:0] shadow_q;
    logic [6:0] ext_index_q;
    logic rd_pend_q;

    assign pri_idx_wr = io_wr && io_addr == RTCIDX_PRI_INDEX_OFS;
    assign ext_idx_wr = io_wr && io_addr == RTCIDX_EXT_INDEX_OFS;
    assign pri_dat = io_addr == RTCIDX_PRI_DATA_OFS;
    assign ext_dat = io_addr == RTCIDX_EXT_DATA_OFS;

    // Primary index with NMI mask, kept whole as the shadow
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            shadow_q <= RTCIDX_INDEX_RST;
        end else if (pri_idx_wr) begin
            shadow_q <= io_wdata;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            nmi_mask <= RTCIDX_NMI_RST[RTCIDX_NMI_BIT];
        end else if (pri_idx_wr) begin
            nmi_mask <= io_wdata[RTCIDX_NMI_BIT];
        end
    end

    // Extended index; bit 7 reserved and dropped
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ext_index_q <= 7'h00;
        end else if (ext_idx_wr) begin
            ext_index_q <= io_wdata[6:0];
        end
    end

    // Latch strobe and index toward the RTC controller
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            index_latch_strobe <= 1'b0;
            latch_index <= 7'h00;
        end else begin
            index_latch_strobe <= pri_idx_wr || ext_idx_wr;
            if (pri_idx_wr || ext_idx_wr) begin
                latch_index <= io_wdata[6:0];
            end
        end
    end

    // ISA forwarding of index writes, one-cycle bus write
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            isa_wr <= 1'b0;
            isa_addr <= 8'h00;
            isa_data <= 8'h00;
        end else begin
            isa_wr <= pri_idx_wr || ext_idx_wr;
            if (pri_idx_wr || ext_idx_wr) begin
                isa_addr <= io_addr;
                isa_data <= io_wdata;
            end
        end
    end

    // Data ports act on the last index of their own pair
    assign mem.we = io_wr && (pri_dat || ext_dat);
    assign mem.waddr = pri_dat ? shadow_q[6:0] : ext_index_q;
    assign mem.wdata = io_wdata;
    assign mem.raddr = pri_dat ? shadow_q[6:0] : ext_index_q;

    // Read answer two cycles after a data-port request; index ports never answer
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_pend_q <= 1'b0;
        end else begin
            rd_pend_q <= io_rd && (pri_dat || ext_dat);
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            io_rvalid <= 1'b0;
            io_rdata <= 8'h00;
        end else begin
            io_rvalid <= rd_pend_q;
            io_rdata <= rd_pend_q ? mem.rdata : 8'h00;
        end
    end

    // Configuration shadow read
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg_shadow_rdata <= 8'h00;
        end else begin
            cfg_shadow_rdata <= (cfg_idx == RTCIDX_SHADOW_IDX) ? shadow_q : 8'h00;
        end
    end

    AST_STROBE: assert property (@(posedge clock) disable iff (!rst_b)
        (io_wr && (io_addr == RTCIDX_PRI_INDEX_OFS || io_addr == RTCIDX_EXT_INDEX_OFS))
        |=> index_latch_strobe && latch_index == $past(io_wdata[6:0]))
        else $error("latch strobe missing");
    AST_ISA: assert property (@(posedge clock) disable iff (!rst_b)
        isa_wr |-> isa_data == $past(io_wdata) && isa_addr == $past(io_addr))
        else $error("isa forward wrong");
    AST_NMI: assert property (@(posedge clock) disable iff (!rst_b)
        (io_wr && io_addr == RTCIDX_PRI_INDEX_OFS) |=> nmi_mask == $past(io_wdata[7]))
        else $error("nmi mask wrong");
    AST_SHADOW: assert property (@(posedge clock) disable iff (!rst_b)
        (io_wr && io_addr == RTCIDX_PRI_INDEX_OFS) ##1 (cfg_idx == RTCIDX_SHADOW_IDX && !io_wr)
        |=> cfg_shadow_rdata == $past(io_wdata, 2))
        else $error("shadow wrong");
    AST_EXT_NO_NMI: assert property (@(posedge clock) disable iff (!rst_b)
        (io_wr && io_addr == RTCIDX_EXT_INDEX_OFS) |=> $stable(nmi_mask))
        else $error("extended write moved nmi mask");
    AST_RVALID: assert property (@(posedge clock) disable iff (!rst_b)
        (io_rd && (io_addr == RTCIDX_PRI_DATA_OFS || io_addr == RTCIDX_EXT_DATA_OFS))
        |-> ##2 io_rvalid)
        else $error("read answer late");
    AST_RDBACK: assert property (@(posedge clock) disable iff (!rst_b)
        (io_wr && io_addr == RTCIDX_PRI_DATA_OFS) ##1
        (io_rd && io_addr == RTCIDX_PRI_DATA_OFS && !io_wr)
        |-> ##2 io_rdata == $past(io_wdata, 3))
        else $error("primary data readback wrong");
    AST_EXT_RDBACK: assert property (@(posedge clock) disable iff (!rst_b)
        (io_wr && io_addr == RTCIDX_EXT_DATA_OFS) ##1
        (io_rd && io_addr == RTCIDX_EXT_DATA_OFS && !io_wr)
        |-> ##2 io_rdata == $past(io_wdata, 3))
        else $error("extended data readback wrong");

    COV_PRI: cover property (@(posedge clock) disable iff (!rst_b)
        (io_wr && io_addr == RTCIDX_PRI_INDEX_OFS) ##1 (io_rd && pri_dat));
    COV_EXT: cover property (@(posedge clock) disable iff (!rst_b)
        (io_wr && io_addr == RTCIDX_EXT_INDEX_OFS) ##1 (io_wr && ext_dat));
    // Index ports are write-only: a read of them must never answer
    AST_IDX_NO_READ: assert property (@(posedge clock) disable iff (!rst_b)
        (io_rd && !io_wr && (io_addr == RTCIDX_PRI_INDEX_OFS || io_addr == RTCIDX_EXT_INDEX_OFS))
        |-> ##2 !io_rvalid)
        else $error("index port answered a read");

    // Read data bus idles at zero so a stale byte is never mistaken for an answer
    AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (!rst_b)
        !io_rvalid |-> io_rdata == 8'h00)
        else $error("read data not idle");

    // Forwarded bus write and latch strobe come from the same index write
    AST_ISA_WITH_STROBE: assert property (@(posedge clock) disable iff (!rst_b)
        isa_wr == index_latch_strobe)
        else $error("isa forward and strobe apart");

    // Extended index keeps its own pair, untouched by primary index writes
    AST_EXT_KEEP: assert property (@(posedge clock) disable iff (!rst_b)
        (io_wr && io_addr == RTCIDX_PRI_INDEX_OFS) |=> $stable(ext_index_q))
        else $error("primary write moved extended index");

    COV_SHADOW: cover property (@(posedge clock) disable iff (!rst_b)
        cfg_idx == RTCIDX_SHADOW_IDX && shadow_q != 8'h00);
    // Readback answer seen, and a masking write seen
    COV_ANSWER: cover property (@(posedge clock) disable iff (!rst_b)
        io_rvalid && io_rdata != 8'h00);
    COV_NMI_MASKED: cover property (@(posedge clock) disable iff (!rst_b)
        $rose(nmi_mask));
endmodule // rtcidx_top

// ===== common/rtcidx_pkg.sv
package rtcidx_pkg;
    localparam logic [7:0] RTCIDX_PRI_INDEX_OFS = 8'h70;
    localparam logic [7:0] RTCIDX_PRI_DATA_OFS = 8'h71;
    localparam logic [7:0] RTCIDX_EXT_INDEX_OFS = 8'h72;
    localparam logic [7:0] RTCIDX_EXT_DATA_OFS = 8'h73;
    localparam logic [7:0] RTCIDX_SHADOW_IDX = 8'hbb;
    localparam int RTCIDX_NMI_BIT = 7;
    localparam logic [7:0] RTCIDX_INDEX_RST = 8'h00;
    localparam logic [7:0] RTCIDX_NMI_RST = 8'h00;
endpackage

// ===== common/rtcidx_mem_if.sv
`timescale 1ns/1ps
// Register-array access between the port front end and the RTC store
interface rtcidx_mem_if;
    logic we;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic [6:0] raddr;
    logic [7:0] rdata;
    modport front (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ===== hw/rtcidx_mem.sv
`timescale 1ns/1ps
// RTC register store, 128 bytes, registered read
module rtcidx_mem (
    input wire logic clock,
    rtcidx_mem_if.store mem
);
    logic [7:0] ram_q [128];
    logic [7:0] rdata_q;

    // Write port
    always_ff @(posedge clock) begin
        if (mem.we) begin
            ram_q[mem.waddr] <= mem.wdata;
        end
    end

    // Read data from a register
    always_ff @(posedge clock) begin
        rdata_q <= ram_q[mem.raddr];
    end

    assign mem.rdata = rdata_q;
endmodule // rtcidx_mem

// ===== sim/rtcidx_rtc_model.sv
`timescale 1ns/1ps
// Stand-in for the RTC controller behind the index latch strobe
module rtcidx_rtc_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic index_latch_strobe,
    input wire logic [6:0] latch_index,
    output logic [6:0] rtc_index_q
);
    // Index is only taken on the strobe, never from a stale bus value
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) rtc_index_q <= 7'h00;
        else if (index_latch_strobe) rtc_index_q <= latch_index;
    end
endmodule // rtcidx_rtc_model

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rtcidx_pkg::*;
    logic clock, rst_b, io_wr, io_rd, io_rvalid, isa_wr, index_latch_strobe, nmi_mask, ok;
    logic [7:0] io_addr, io_wdata, cfg_idx, io_rdata, isa_addr, isa_data, cfg_shadow_rdata;
    logic [7:0] s, v, d0, d1, got;
    logic [6:0] latch_index, rtc_index;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    rtcidx_top i_dut (.clock(clock), .rst_b(rst_b), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .cfg_idx(cfg_idx), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .isa_wr(isa_wr), .isa_addr(isa_addr), .isa_data(isa_data),
        .index_latch_strobe(index_latch_strobe), .latch_index(latch_index),
        .nmi_mask(nmi_mask), .cfg_shadow_rdata(cfg_shadow_rdata));
    rtcidx_rtc_model i_rtc (.clock(clock), .rst_b(rst_b),
        .index_latch_strobe(index_latch_strobe), .latch_index(latch_index),
        .rtc_index_q(rtc_index));
    // Free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    function automatic logic [7:0] nx(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // One-cycle write pulse, released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        io_wr <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge clock);
        io_wr <= 1'b0;
        #1;
    endtask
    // Answer may come a couple of cycles late, so poll a short window
    task automatic rd(input logic [7:0] a, output logic [7:0] r, output logic f);
        r = 8'h00;
        f = 1'b0;
        @(posedge clock);
        io_rd <= 1'b1;
        io_addr <= a;
        @(posedge clock);
        io_rd <= 1'b0;
        repeat (3) begin
            @(posedge clock);
            #1;
            if (io_rvalid === 1'b1) begin
                f = 1'b1;
                r = io_rdata;
            end
        end
    endtask
    task automatic idx(input logic [7:0] a, input logic [7:0] d, input logic n);
        wr(a, d);
        chk("isa_wr", {7'h00, isa_wr}, 8'h01);
        chk("isa_addr", isa_addr, a);
        chk("isa_data", isa_data, d);
        chk("strobe", {7'h00, index_latch_strobe}, 8'h01);
        chk("latch_index", {1'b0, latch_index}, {1'b0, d[6:0]});
        chk("nmi_mask", {7'h00, nmi_mask}, {7'h00, n});
        @(posedge clock);
        #1;
        chk("strobe_pulse", {7'h00, index_latch_strobe}, 8'h00);
        chk("rtc_index", {1'b0, rtc_index}, {1'b0, d[6:0]});
        if (a == RTCIDX_PRI_INDEX_OFS) chk("shadow", cfg_shadow_rdata, d);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Corner indexes first, then random ones; each pair keeps its own index
    initial begin
        rst_b = 1'b0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 8'h00;
        io_wdata = 8'h00;
        cfg_idx = RTCIDX_SHADOW_IDX;
        s = 8'h49;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        #1;
        chk("rst_isa_wr", {7'h00, isa_wr}, 8'h00);
        chk("rst_strobe", {7'h00, index_latch_strobe}, 8'h00);
        chk("rst_nmi", {7'h00, nmi_mask}, RTCIDX_NMI_RST);
        for (int i = 0; i < 10; i++) begin
            s = nx(s);
            v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : s;
            idx(RTCIDX_PRI_INDEX_OFS, v, v[7]);
            d0 = nx(s);
            wr(RTCIDX_PRI_DATA_OFS, d0);
            idx(RTCIDX_EXT_INDEX_OFS, ~v ^ 8'h80, v[7]);
            d1 = nx(d0);
            wr(RTCIDX_EXT_DATA_OFS, d1);
            rd(RTCIDX_PRI_DATA_OFS, got, ok);
            chk("pri_data", got, d0);
            chk("pri_valid", {7'h00, ok}, 8'h01);
            rd(RTCIDX_EXT_DATA_OFS, got, ok);
            chk("ext_data", got, d1);
            chk("ext_valid", {7'h00, ok}, 8'h01);
        end
        rd(RTCIDX_PRI_INDEX_OFS, got, ok);
        chk("pri_index_read", {7'h00, ok}, 8'h00);
        rd(RTCIDX_EXT_INDEX_OFS, got, ok);
        chk("ext_index_read", {7'h00, ok}, 8'h00);
        cfg_idx <= 8'h00;
        repeat (2) @(posedge clock);
        #1;
        chk("shadow_off", cfg_shadow_rdata, 8'h00);
        tally_and_finish();
    end
endmodule // tb_top
